// *** spio_pkg.sv ***
// register map and reset values of the shared pin i/o port
package spio_pkg;
    localparam logic [7:0]  SPIO_DIR_OFS     = 8'h00;
    localparam logic [7:0]  SPIO_LAT_OFS     = 8'h04;
    localparam logic [7:0]  SPIO_PIN_OFS     = 8'h08;
    localparam logic [7:0]  SPIO_ODC_OFS     = 8'h0C;
    localparam logic [7:0]  SPIO_ANA_OFS     = 8'h10;
    localparam logic [7:0]  SPIO_ANA2_OFS    = 8'h14;
    localparam logic [7:0]  SPIO_CNEN_LO_OFS = 8'h18;
    localparam logic [7:0]  SPIO_CNEN_HI_OFS = 8'h1C;
    localparam logic [7:0]  SPIO_CNPU_LO_OFS = 8'h20;
    localparam logic [7:0]  SPIO_CNPU_HI_OFS = 8'h24;
    localparam logic [7:0]  SPIO_STAT_OFS    = 8'h28;
    localparam logic [15:0] SPIO_DIR_RST     = 16'hFFFF;
    localparam logic [15:0] SPIO_LAT_RST     = 16'h0000;
    localparam logic [15:0] SPIO_ODC_RST     = 16'h0000;
    localparam logic [15:0] SPIO_ANA_RST     = 16'h0000;
    localparam logic [15:0] SPIO_CN_RST      = 16'h0000;
    localparam int          SPIO_STAT_CHG    = 0;
    localparam int          SPIO_CN_LO_N     = 16;
endpackage

// *** spio_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module spio_sync #(
    parameter int W = 16
) (
    input  wire logic         clk,   // core clock
    input  wire logic         rst_n, // synchronous reset, active low
    input  wire logic [W-1:0] d,     // asynchronous inputs
    output logic      [W-1:0] q      // filtered, synchronous levels
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] next_q;

    // a level counts only once stages two and three agree
    always_comb begin
        next_q = ((s2 ^ s3) & q) | (~(s2 ^ s3) & s3);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            q  <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            q  <= next_q;
        end
    end
endmodule

// *** spio_port.sv ***
// shared pin i/o port with change notice, classic wishbone slave
//
// Behaviour
// R1: active peripheral owns pin, readback stays
// R2: idle peripheral lets port drive from latch
// R3: port output never loops into peripheral
// R4: direction one is input, zero output
// R5: all pins inputs after reset
// R6: latch reads latch, writes latch only
// R7: pin state reads pins, writes latch
// R8: unimplemented bits read zero everywhere; the analog config registers keep them as written
// R9: open-drain bit makes output open drain; only the latch drive obeys it, a pin owned by a peripheral still drives high
// R10: analog config registers reset to zero
// R11: analog pins read low in pin state
// R12: software keeps analog pins as inputs
// R13: software waits a cycle before readback
// R14: enabled pin change raises interrupt request
// R15: change detection works without the clock
// R16: up to thirty selectable change inputs
// R17: per-pin change enable in two registers
// R18: per-pin weak pull-up in two registers
// R19: compare to previous level, hold until acked
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
module spio_port
    import spio_pkg::*;
#(
    parameter int             W         = 16,
    parameter int             CN_N      = 30,
    parameter logic [W-1:0]   IMPL_MASK = '1,
    parameter logic [W-1:0]   ANA_MASK  = '1
) (
    input  wire logic            CORE_CLK,   // core clock, 20 MHz
    input  wire logic            RST_N,      // synchronous reset
    input  wire logic [7:0]      ADR_I,      // wishbone byte address
    input  wire logic [31:0]     DAT_I,      // wishbone write data
    output logic      [31:0]     DAT_O,      // wishbone read data
    input  wire logic [3:0]      SEL_I,      // wishbone byte lanes
    input  wire logic            WE_I,       // wishbone write
    input  wire logic            CYC_I,      // wishbone cycle
    input  wire logic            STB_I,      // wishbone strobe
    output logic                 ACK_O,      // wishbone acknowledge
    input  wire logic [W-1:0]    PIN_IN,     // pin levels
    output logic      [W-1:0]    PIN_OUT,    // pin drive value
    output logic      [W-1:0]    PIN_OE_N,   // pin driver enable
    input  wire logic [W-1:0]    PERIPH_OE,  // peripheral drives pin
    input  wire logic [W-1:0]    PERIPH_OUT, // peripheral drive value
    output logic      [W-1:0]    PERIPH_IN,  // pin level to peripheral
    input  wire logic [CN_N-1:0] CN_PIN,     // change notice inputs
    output logic      [CN_N-1:0] PULLUP_EN,  // weak pull-up enables
    output logic                 CN_IRQ,     // change interrupt request
    output logic                 CN_WAKE     // clockless wake request
);
    localparam int HI_N = CN_N - SPIO_CN_LO_N;

    ////////////////////////////////////////////////////////////////////
    logic [W-1:0]    dir;
    logic [W-1:0]    lat;
    logic [W-1:0]    odc;
    logic [15:0]     ana;
    logic [15:0]     ana2;
    logic [CN_N-1:0] cnen;
    logic [CN_N-1:0] cn_prev;
    logic            chg_flag;
    logic [W-1:0]    next_dir;
    logic [W-1:0]    next_lat;
    logic [W-1:0]    next_odc;
    logic [15:0]     next_ana;
    logic [15:0]     next_ana2;
    logic [CN_N-1:0] next_cnen;
    logic [CN_N-1:0] next_pu;
    logic            next_chg_flag;
    logic            next_ack;
    logic [31:0]     next_dat;
    logic [W-1:0]    pin_f;
    logic [CN_N-1:0] cn_f;
    logic [W-1:0]    an_bits;
    logic [W-1:0]    pin_rd;
    logic            bus_go;
    logic            wr_go;
    logic            rd_go;
    logic            clr;
    logic            chg;
    logic [5:0]      idx;

    function automatic logic [15:0] upd(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
        logic [15:0] m;
        m   = {{8{s[1]}}, {8{s[0]}}};
        upd = (old & ~m) | (d[15:0] & m);
    endfunction

    spio_sync #(.W(W)) u_pin_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .d     (PIN_IN),
        .q     (pin_f)
    );

    spio_sync #(.W(CN_N)) u_cn_sync (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .d     (CN_PIN),
        .q     (cn_f)
    );

    ////////////////////////////////////////////////////////////////////
    // bus decode: one wait state, ack drops the cycle after it rose
    assign idx    = ADR_I[7:2];
    assign bus_go = CYC_I & STB_I & ~ACK_O;
    assign wr_go  = bus_go & WE_I;
    assign rd_go  = bus_go & ~WE_I;
    assign clr    = wr_go & (idx == SPIO_STAT_OFS[7:2]) & SEL_I[0]
                    & DAT_I[SPIO_STAT_CHG];
    // analog config zero means analog; digital buffer reads low
    assign an_bits = ~ana[W-1:0] & ANA_MASK;
    assign pin_rd  = pin_f & ~an_bits & IMPL_MASK; // see R7 see R11

    always_comb begin
        next_ack = bus_go;
        next_dat = 32'h0000_0000;
        if (rd_go) begin
            case (idx)
                SPIO_DIR_OFS[7:2]:     next_dat = 32'(dir);
                SPIO_LAT_OFS[7:2]:     next_dat = 32'(lat); // see R6
                SPIO_PIN_OFS[7:2]:     next_dat = 32'(pin_rd);
                SPIO_ODC_OFS[7:2]:     next_dat = 32'(odc);
                SPIO_ANA_OFS[7:2]:     next_dat = 32'(ana);
                SPIO_ANA2_OFS[7:2]:    next_dat = 32'(ana2);
                SPIO_CNEN_LO_OFS[7:2]: next_dat = 32'(cnen[15:0]);
                SPIO_CNEN_HI_OFS[7:2]: next_dat = 32'(cnen[CN_N-1:16]);
                SPIO_CNPU_LO_OFS[7:2]: next_dat = 32'(PULLUP_EN[15:0]);
                SPIO_CNPU_HI_OFS[7:2]:
                    next_dat = 32'(PULLUP_EN[CN_N-1:16]);
                SPIO_STAT_OFS[7:2]:    next_dat = 32'(chg_flag);
                default:               next_dat = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes; unimplemented bits of dir, lat and odc are masked off at storage
    always_comb begin
        next_dir  = dir;
        next_lat  = lat;
        next_odc  = odc;
        next_ana  = ana;
        next_ana2 = ana2;
        next_cnen = cnen;
        next_pu   = PULLUP_EN;
        if (wr_go) begin
            case (idx)
                SPIO_DIR_OFS[7:2]:
                    next_dir = W'(upd(16'(dir), DAT_I, SEL_I))
                               & IMPL_MASK; // see R4 see R8
                SPIO_LAT_OFS[7:2], SPIO_PIN_OFS[7:2]:
                    next_lat = W'(upd(16'(lat), DAT_I, SEL_I))
                               & IMPL_MASK; // see R6 see R7
                SPIO_ODC_OFS[7:2]:
                    next_odc = W'(upd(16'(odc), DAT_I, SEL_I))
                               & IMPL_MASK; // see R9
                SPIO_ANA_OFS[7:2]:  next_ana  = upd(ana, DAT_I, SEL_I);
                SPIO_ANA2_OFS[7:2]: next_ana2 = upd(ana2, DAT_I, SEL_I);
                SPIO_CNEN_LO_OFS[7:2]:
                    next_cnen[15:0] = upd(cnen[15:0], DAT_I, SEL_I);
                SPIO_CNEN_HI_OFS[7:2]:
                    next_cnen[CN_N-1:16] = HI_N'(upd(16'(cnen[CN_N-1:16]),
                                        DAT_I, SEL_I)); // see R17
                SPIO_CNPU_LO_OFS[7:2]:
                    next_pu[15:0] = upd(PULLUP_EN[15:0], DAT_I, SEL_I);
                SPIO_CNPU_HI_OFS[7:2]:
                    next_pu[CN_N-1:16] = HI_N'(upd(16'(PULLUP_EN[CN_N-1:16]),
                                        DAT_I, SEL_I)); // see R18
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // change notice: synchronised level against last captured level
    logic [W-1:0] per_drv;
    logic [W-1:0] port_drv;
    logic [W-1:0] next_pin_out;
    logic [W-1:0] next_oe_n;
    logic [W-1:0] next_per_in;

    always_comb begin
        chg           = |(cnen & (cn_f ^ cn_prev)); // see R14 see R19
        // a new change wins over a clear in the same cycle
        next_chg_flag = chg | (chg_flag & ~clr); // see R19
    end

    // sleep path: raw pins against the held level, no clock needed
    assign CN_WAKE = |(cnen & (CN_PIN ^ cn_prev)); // see R15 see R16

    ////////////////////////////////////////////////////////////////////
    // output ownership: active peripheral first, then port latch
    always_comb begin
        per_drv  = PERIPH_OE & IMPL_MASK; // see R1
        port_drv = ~PERIPH_OE & ~dir & IMPL_MASK; // see R2 see R4
        next_pin_out = (per_drv & PERIPH_OUT)
                       | (port_drv & ~odc & lat);
        // open drain only sinks; a latched one releases the pin
        next_oe_n = ~(per_drv | (port_drv & ~(odc & lat))); // see R9
        // peripheral never sees the port's own drive
        next_per_in = pin_f & ~port_drv & IMPL_MASK; // see R3
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            dir       <= SPIO_DIR_RST[W-1:0] & IMPL_MASK; // see R5
            lat       <= SPIO_LAT_RST[W-1:0];
            odc       <= SPIO_ODC_RST[W-1:0];
            ana       <= SPIO_ANA_RST; // see R10
            ana2      <= SPIO_ANA_RST; // see R10
            cnen      <= CN_N'(SPIO_CN_RST);
            PULLUP_EN <= CN_N'(SPIO_CN_RST);
            cn_prev   <= CN_N'(SPIO_CN_RST);
            chg_flag  <= 1'b0;
            CN_IRQ    <= 1'b0;
            ACK_O     <= 1'b0;
            DAT_O     <= 32'h0000_0000;
            PIN_OUT   <= '0;
            PIN_OE_N  <= '1;
            PERIPH_IN <= '0;
        end else begin
            dir       <= next_dir;
            lat       <= next_lat;
            odc       <= next_odc;
            ana       <= next_ana;
            ana2      <= next_ana2;
            cnen      <= next_cnen;
            PULLUP_EN <= next_pu;
            cn_prev   <= cn_f;
            chg_flag  <= next_chg_flag;
            CN_IRQ    <= next_chg_flag;
            ACK_O     <= next_ack;
            DAT_O     <= next_dat;
            PIN_OUT   <= next_pin_out;
            PIN_OE_N  <= next_oe_n;
            PERIPH_IN <= next_per_in;
        end
    end

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);

    property p_rst_dir;
        disable iff (1'b0) !RST_N |=> dir == IMPL_MASK;
    endproperty
    a_rst_dir: assert property (p_rst_dir) // see R5
        else $error("direction not all inputs after reset");
    property p_rst_ana;
        disable iff (1'b0) !RST_N |=> (ana == 16'h0000 && ana2 == 16'h0000);
    endproperty
    a_rst_ana: assert property (p_rst_ana) // see R10
        else $error("analog config not zero after reset");
    property p_periph;
        PERIPH_OE[6] && IMPL_MASK[6]
            |=> !PIN_OE_N[6] && PIN_OUT[6] == $past(PERIPH_OUT[6]);
    endproperty
    a_periph: assert property (p_periph) // see R1
        else $error("peripheral did not own the pin");

    property p_port;
        !PERIPH_OE[0] && !dir[0] && !odc[0] && IMPL_MASK[0]
            |=> !PIN_OE_N[0] && PIN_OUT[0] == $past(lat[0]);
    endproperty
    a_port: assert property (p_port) // see R2
        else $error("port did not drive latch value");
    property p_loop;
        !PERIPH_OE[0] && !dir[0] |=> !PERIPH_IN[0];
    endproperty
    a_loop: assert property (p_loop) // see R3
        else $error("port output looped into peripheral");

    property p_dir_in;
        !PERIPH_OE[0] && dir[0] |=> PIN_OE_N[0];
    endproperty
    a_dir_in: assert property (p_dir_in) // see R4
        else $error("input pin is driven");

    property p_lat_wr;
        wr_go && idx == SPIO_LAT_OFS[7:2] && SEL_I[1:0] == 2'b11
            |=> lat == ($past(DAT_I[W-1:0]) & IMPL_MASK)
                ##1 ACK_O == 1'b0;
    endproperty
    a_lat_wr: assert property (p_lat_wr) // see R6
        else $error("latch write lost or ack held");

    property p_pin_rd;
        rd_go && idx == SPIO_PIN_OFS[7:2]
            |=> ACK_O && DAT_O[W-1:0] == ($past(pin_f)
                & ~$past(an_bits) & IMPL_MASK);
    endproperty
    a_pin_rd: assert property (p_pin_rd) // see R7 see R11
        else $error("pin state read wrong");

    property p_unimp;
        ((dir | lat | PIN_OUT | PERIPH_IN) & ~IMPL_MASK) == '0;
    endproperty
    a_unimp: assert property (p_unimp) // see R8
        else $error("unimplemented bit not zero");
    property p_od;
        !PERIPH_OE[7] && !dir[7] && odc[7] && lat[7] |=> PIN_OE_N[7];
    endproperty
    a_od: assert property (p_od) // see R9
        else $error("open drain pin driven high");

    property p_irq_set;
        chg |=> CN_IRQ ##1 (CN_IRQ || $past(clr));
    endproperty
    a_irq_set: assert property (p_irq_set) // see R14
        else $error("change did not raise request");

    property p_irq_hold;
        CN_IRQ && !clr && !chg |=> CN_IRQ;
    endproperty
    a_irq_hold: assert property (p_irq_hold) // see R19
        else $error("request dropped without acknowledge");

    property p_irq_mask;
        !CN_IRQ && cnen == '0 |=> !CN_IRQ;
    endproperty
    a_irq_mask: assert property (p_irq_mask) // see R17
        else $error("request from disabled input");
    property p_wake;
        cnen[0] && (CN_PIN[0] != cn_prev[0]) |-> CN_WAKE;
    endproperty
    a_wake: assert property (p_wake) // see R15
        else $error("wake missing on raw change");

    c_irq:    cover property (chg ##1 CN_IRQ ##[1:20] clr);
    c_periph: cover property (PERIPH_OE[6] ##1 !PERIPH_OE[6]);
    c_od:     cover property (odc[7] && !dir[7] && lat[7]);
    c_pinrd:  cover property (rd_go && idx == SPIO_PIN_OFS[7:2]);
endmodule

// *** spio_pins_model.sv ***
// far-side model: package pins, board drivers and change-notice lines
`timescale 1ns/1ns
module spio_pins_model
    import spio_pkg::*;
#(
    parameter int W    = 16,
    parameter int CN_N = 30
) (
    input  wire logic            clk,      // core clock
    input  wire logic [W-1:0]    pin_out,  // port drive value
    input  wire logic [W-1:0]    pin_oe_n, // port drive enable, low
    input  wire logic [W-1:0]    ext_en,   // board drives the pin
    input  wire logic [W-1:0]    ext_val,  // board drive value
    input  wire logic [CN_N-1:0] cn_en,    // board drives the cn line
    input  wire logic [CN_N-1:0] cn_val,   // board cn value
    input  wire logic [CN_N-1:0] pu_en,    // weak pull-up enables
    output logic      [W-1:0]    pin_lvl,  // resolved pin level
    output logic      [CN_N-1:0] cn_lvl    // resolved cn level
);
    logic flt = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // undriven lines wander so a stale level never passes for a real one
    always @(posedge clk) begin
        flt <= ~flt;
    end

    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin_lvl[i] = !pin_oe_n[i] ? pin_out[i]
                       : (ext_en[i] ? ext_val[i] : flt);
        end
        for (int i = 0; i < CN_N; i++) begin
            cn_lvl[i] = cn_en[i] ? cn_val[i]
                      : (pu_en[i] ? 1'b1 : flt);
        end
    end
endmodule

// *** spio_port_tb.sv ***
// self-checking bench for the shared pin i/o port
`timescale 1ns/1ns
module spio_port_tb;
    import spio_pkg::*;
    localparam int          W    = 16;
    localparam int          CN_N = 30;
    localparam logic [15:0] IMPL = 16'h7FFF;

    logic            clk      = 1'b0;
    logic            rst_n    = 1'b0;
    logic [7:0]      adr      = 8'h00;
    logic [31:0]     dat_w    = 32'h0000_0000;
    logic [3:0]      sel      = 4'h0;
    logic            we       = 1'b0;
    logic            cyc      = 1'b0;
    logic            stb      = 1'b0;
    logic [W-1:0]    p_oe     = 16'h0000;
    logic [W-1:0]    p_out    = 16'h0000;
    logic [W-1:0]    ext_val  = 16'h0000;
    logic [CN_N-1:0] cn_val   = '0;
    logic [31:0]     dat_r;
    logic            ack;
    logic [W-1:0]    pin_lvl;
    logic [W-1:0]    pin_out;
    logic [W-1:0]    pin_oe_n;
    logic [W-1:0]    p_in;
    logic [CN_N-1:0] cn_lvl;
    logic [CN_N-1:0] pu_en;
    logic            irq;
    logic            wake;
    logic [31:0]     q;
    int              fails    = 0;
    int              compares = 0;

    always #25 clk = ~clk;

    spio_port #(.W(W), .CN_N(CN_N), .IMPL_MASK(IMPL)) dut (
        .CORE_CLK(clk), .RST_N(rst_n), .ADR_I(adr), .DAT_I(dat_w),
        .DAT_O(dat_r), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb),
        .ACK_O(ack), .PIN_IN(pin_lvl), .PIN_OUT(pin_out),
        .PIN_OE_N(pin_oe_n), .PERIPH_OE(p_oe), .PERIPH_OUT(p_out),
        .PERIPH_IN(p_in), .CN_PIN(cn_lvl), .PULLUP_EN(pu_en),
        .CN_IRQ(irq), .CN_WAKE(wake));

    spio_pins_model #(.W(W), .CN_N(CN_N)) pins (
        .clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en('1),
        .ext_val(ext_val), .cn_en('1), .cn_val(cn_val), .pu_en(pu_en),
        .pin_lvl(pin_lvl), .cn_lvl(cn_lvl));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [15:0] d, output logic [31:0] r);
        int n;
        @(posedge clk);
        adr <= a;
        we <= w;
        dat_w <= {16'h0000, d};
        sel <= 4'h3;
        cyc <= 1'b1;
        stb <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        r = dat_r;
        if (n >= 50) fails++;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        wb(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        wb(a, 1'b0, 16'h0000, q);
        chk(q, {16'h0000, e});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic conclude;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // run is under two hundred cycles; this limit is far beyond it
    initial begin
        #(50 * 20000);
        fails++;
        conclude();
    end

    initial begin
        int ch;
        int n;
        idle(10);
        rst_n <= 1'b1;
        @(posedge clk);
        chk(pin_oe_n, 16'hFFFF);
        rd(SPIO_DIR_OFS, IMPL);
        rd(SPIO_ANA_OFS, 16'h0000);
        rd(SPIO_ANA2_OFS, 16'h0000);
        wr(SPIO_LAT_OFS, 16'hFFFF);
        rd(SPIO_LAT_OFS, IMPL);
        wr(SPIO_PIN_OFS, 16'h00A5);
        rd(SPIO_LAT_OFS, 16'h00A5);
        wr(SPIO_ANA_OFS, 16'hFFFF);
        ext_val <= 16'hDA00;
        wr(SPIO_DIR_OFS, 16'hFF00);
        idle(8);
        chk(pin_oe_n[14:0], 15'h7F00);
        chk(pin_out[7:0], 8'hA5);
        chk(p_in[7:0], 8'h00);
        chk(p_in[14:8], 7'h5A);
        ext_val <= 16'hDAAF;
        wr(SPIO_DIR_OFS, 16'hFF0F);
        idle(8);
        rd(SPIO_PIN_OFS, 16'h5AAF);
        wr(SPIO_ANA_OFS, 16'hFFF0);
        idle(8);
        rd(SPIO_PIN_OFS, 16'h5AA0);
        wr(SPIO_ODC_OFS, 16'h00F0);
        idle(3);
        chk(pin_oe_n[7:4], 4'hA);
        chk(pin_out[7:4], 4'h0);
        p_out <= 16'h0040;
        p_oe <= 16'h0040;
        idle(8);
        chk(pin_oe_n[6], 1'b0);
        chk(pin_out[6], 1'b1);
        rd(SPIO_PIN_OFS, 16'h5AE0);
        p_oe <= 16'h0000;
        idle(3);
        chk(pin_out[6], 1'b0);
        chk(pin_oe_n[6], 1'b0);
        wr(SPIO_CNEN_LO_OFS, 16'h0008);
        wr(SPIO_CNEN_HI_OFS, 16'h2000);
        for (int k = 0; k < 2; k++) begin
            ch = (k == 0) ? 3 : 29;
            cn_val[ch] <= 1'b1;
            @(posedge clk);
            chk(wake, 1'b1);
            n = 0;
            while (irq !== 1'b1 && n < 20) begin
                @(posedge clk);
                n++;
            end
            chk(irq, 1'b1);
            rd(SPIO_STAT_OFS, 16'h0001);
            chk(irq, 1'b1);
            wr(SPIO_STAT_OFS, 16'h0001);
            idle(2);
            chk(irq, 1'b0);
            chk(wake, 1'b0);
        end
        // a disabled line must stay silent
        cn_val[5] <= 1'b1;
        idle(10);
        chk(irq, 1'b0);
        chk(wake, 1'b0);
        wr(SPIO_CNPU_LO_OFS, 16'h0001);
        wr(SPIO_CNPU_HI_OFS, 16'h0002);
        idle(2);
        chk(pu_en, 30'h0002_0001);
        rd(8'h30, 16'h0000);
        conclude();
    end
endmodule
